//--- hdl/vip_defines.svh
`ifndef VIP_DEFINES_SVH
`define VIP_DEFINES_SVH

`define VIP_ADDR_CLK_CTRL   8'h80
`define VIP_ADDR_REF_SEL    8'h84
`define VIP_ADDR_POLARITY   8'h85
`define VIP_ADDR_PORT_EN    8'h87
`define VIP_ADDR_FORMAT     8'h8e
`define VIP_ADDR_STATUS     8'h8f
`define VIP_ADDR_MODE       8'h93

`define VIP_RST_CLK_CTRL    3'h0
`define VIP_RST_REF_SEL     8'h00
`define VIP_RST_POLARITY    8'h00
`define VIP_RST_PORT_EN     2'h3
`define VIP_RST_FORMAT      3'h0
`define VIP_RST_MODE        2'h0

`define VIP_BIT_GATED       2
`define VIP_BIT_QPOL        0
`define VIP_BIT_HPOL        1
`define VIP_BIT_VPOL        2
`define VIP_BIT_BPOL        3
`define VIP_BIT_APOL        4
`define VIP_BIT_RECODE      2
`define VIP_BIT_CODES       7
`define VIP_BIT_WIDE        6

`define VIP_BYTE_INVALID    8'h00
`define VIP_BYTE_FF         8'hff
`define VIP_CLIP_LOW        8'h01
`define VIP_CLIP_HIGH       8'hfe
`define VIP_RECODE_LOW      8'h03
`define VIP_RECODE_HIGH     8'hfc
`define VIP_ANC_DID         8'h5a
`define VIP_ANC_SDID        8'h01
`define VIP_CODE_LEN        3'd4
`define VIP_ANC_HDR_LEN     3'd6

`define VIP_REF_CLK_KHZ     25000
`define VIP_PORT_MAX_KHZ    33000
`define VIP_PORT_MIN_GAP    ((`VIP_REF_CLK_KHZ + `VIP_PORT_MAX_KHZ - 1) / `VIP_PORT_MAX_KHZ)

`endif

//--- hdl/vip_image_port.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "vip_defines.svh"

module vip_image_port #(
   parameter int VBI_DEPTH = 64,
   parameter int CNT_W     = $clog2(VBI_DEPTH + 1)
) (
   input  wire logic                  REF_CLK_IN,
   input  wire logic                  RESETN_IN,
   input  wire logic [7:0]            REG_ADDR_IN,
   input  wire logic [7:0]            REG_WDATA_IN,
   input  wire logic                  REG_WR_IN,
   input  wire logic                  REG_RD_IN,
   output logic      [7:0]            REG_RDATA_OUT,
   input  wire logic                  PORT_CLOCK_PIN_IN,
   input  wire logic                  LLC_CLK_IN,
   input  wire logic                  XCLK_IN,
   input  wire logic                  TARGET_READY_IN,
   input  wire logic                  PORT_FLOAT_IN,
   input  wire vip_pkg::vip_dword_t    SC_DWORD_IN,
   input  wire logic                  SC_VALID_IN,
   output logic                       SC_READY_OUT,
   input  wire logic                  SC_HGATE_IN,
   input  wire logic                  SC_VGATE_IN,
   input  wire vip_pkg::vip_vbi_byte_t VBI_BYTE_IN,
   input  wire logic                  VBI_VALID_IN,
   output logic                       VBI_READY_OUT,
   output logic                       PORT_CLOCK_PIN_OUT,
   output logic                       PORT_CLOCK_PIN_OE_OUT,
   output logic      [7:0]            LOW_DATA_PINS_OUT,
   output logic                       LOW_DATA_PINS_OE_OUT,
   output logic      [7:0]            EXTENSION_DATA_PINS_OUT,
   output logic                       EXTENSION_DATA_PINS_OE_OUT,
   output logic                       DATA_VALID_QUALIFIER_OUT,
   output logic                       HORIZ_REFERENCE_OUT,
   output logic                       VERT_REFERENCE_OUT,
   output logic                       GENERAL_FLAG_OUT_A,
   output logic                       GENERAL_FLAG_OUT_B,
   output logic                       CTRL_PINS_OE_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [7:0] dw_byte(input logic [31:0] d, input logic [1:0] i);
      case (i)
         2'h0:    dw_byte = d[7:0];
         2'h1:    dw_byte = d[15:8];
         2'h2:    dw_byte = d[23:16];
         default: dw_byte = d[31:24];
      endcase
   endfunction

   function automatic logic [7:0] clip(input logic [7:0] b);
      if (b == `VIP_BYTE_INVALID) begin
         clip = `VIP_CLIP_LOW;
      end else if (b == `VIP_BYTE_FF) begin
         clip = `VIP_CLIP_HIGH;
      end else begin
         clip = b;
      end
   endfunction

   function automatic logic [7:0] recode(input logic [7:0] b);
      if (b == `VIP_BYTE_INVALID) begin
         recode = `VIP_RECODE_LOW;
      end else if (b == `VIP_BYTE_FF) begin
         recode = `VIP_RECODE_HIGH;
      end else begin
         recode = b;
      end
   endfunction

   function automatic logic [7:0] code_byte(input logic [2:0] i, input logic f, input logic v, input logic h);
      case (i)
         3'd0:    code_byte = `VIP_BYTE_FF;
         3'd1:    code_byte = `VIP_BYTE_INVALID;
         3'd2:    code_byte = `VIP_BYTE_INVALID;
         default: code_byte = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
      endcase
   endfunction

   function automatic logic [7:0] anc_byte(input logic [2:0] i, input logic [7:0] cnt);
      case (i)
         3'd0:    anc_byte = `VIP_BYTE_INVALID;
         3'd1:    anc_byte = `VIP_BYTE_FF;
         3'd2:    anc_byte = `VIP_BYTE_FF;
         3'd3:    anc_byte = `VIP_ANC_DID;
         3'd4:    anc_byte = `VIP_ANC_SDID;
         default: anc_byte = cnt;
      endcase
   endfunction

   function automatic logic ref_fn(input logic [1:0] sel, input logic gate, input logic pulse, input logic alt);
      case (sel)
         2'h0:    ref_fn = gate;
         2'h1:    ref_fn = pulse;
         2'h2:    ref_fn = alt;
         default: ref_fn = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [2:0]  clk_ctrl_q;
   logic [7:0]  ref_sel_q;
   logic [7:0]  pol_q;
   logic [1:0]  port_en_q;
   logic [2:0]  fmt_q;
   logic [1:0]  mode_q;
   logic [7:0]  rdata_q;
   logic [7:0]  status;
   logic [7:0]  rd_mux;
   logic        wr_clk, wr_ref, wr_pol, wr_en, wr_fmt, wr_mode;

   assign wr_clk  = REG_WR_IN && (REG_ADDR_IN == `VIP_ADDR_CLK_CTRL);
   assign wr_ref  = REG_WR_IN && (REG_ADDR_IN == `VIP_ADDR_REF_SEL);
   assign wr_pol  = REG_WR_IN && (REG_ADDR_IN == `VIP_ADDR_POLARITY);
   assign wr_en   = REG_WR_IN && (REG_ADDR_IN == `VIP_ADDR_PORT_EN);
   assign wr_fmt  = REG_WR_IN && (REG_ADDR_IN == `VIP_ADDR_FORMAT);
   assign wr_mode = REG_WR_IN && (REG_ADDR_IN == `VIP_ADDR_MODE);

   assign rd_mux = (REG_ADDR_IN == `VIP_ADDR_CLK_CTRL) ? {5'h00, clk_ctrl_q} :
                   (REG_ADDR_IN == `VIP_ADDR_REF_SEL)  ? ref_sel_q :
                   (REG_ADDR_IN == `VIP_ADDR_POLARITY) ? pol_q :
                   (REG_ADDR_IN == `VIP_ADDR_PORT_EN)  ? {6'h00, port_en_q} :
                   (REG_ADDR_IN == `VIP_ADDR_FORMAT)   ? {5'h00, fmt_q} :
                   (REG_ADDR_IN == `VIP_ADDR_STATUS)   ? status :
                   (REG_ADDR_IN == `VIP_ADDR_MODE)     ? {mode_q, 6'h00} : 8'h00;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         clk_ctrl_q <= `VIP_RST_CLK_CTRL;
         ref_sel_q  <= `VIP_RST_REF_SEL;
         pol_q      <= `VIP_RST_POLARITY;
         port_en_q  <= `VIP_RST_PORT_EN;
         fmt_q      <= `VIP_RST_FORMAT;
         mode_q     <= `VIP_RST_MODE;
         rdata_q    <= 8'h00;
      end else begin
         if (wr_clk) clk_ctrl_q <= REG_WDATA_IN[2:0];
         if (wr_ref) ref_sel_q <= REG_WDATA_IN;
         if (wr_pol) pol_q <= REG_WDATA_IN;
         if (wr_en) port_en_q <= REG_WDATA_IN[1:0];
         if (wr_fmt) fmt_q <= REG_WDATA_IN[2:0];
         if (wr_mode) mode_q <= REG_WDATA_IN[7:6];
         rdata_q <= REG_RD_IN ? rd_mux : 8'h00;
      end
   end

   assign REG_RDATA_OUT = rdata_q;

   vip_pkg::vip_clk_src_t clk_src;
   vip_pkg::vip_format_t  fmt;
   logic                  codes, wide, recode_on, gated;

   assign clk_src   = vip_pkg::vip_clk_src_t'(clk_ctrl_q[1:0]);
   assign gated     = clk_ctrl_q[`VIP_BIT_GATED];
   assign fmt       = vip_pkg::vip_format_t'(fmt_q[1:0]);
   assign recode_on = fmt_q[`VIP_BIT_RECODE];
   assign codes     = mode_q[`VIP_BIT_CODES - 6];
   assign wide      = mode_q[`VIP_BIT_WIDE - 6];

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and port clock

   logic [4:0] sync1_q, sync2_q;
   logic       clk_prev_q, sel_clk, fall, trdy, float_s;
   logic [3:0] gap_q;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {PORT_FLOAT_IN, TARGET_READY_IN, XCLK_IN, LLC_CLK_IN, PORT_CLOCK_PIN_IN};
         sync2_q <= sync1_q;
      end
   end

   assign sel_clk = (clk_src == vip_pkg::VIP_CLK_PIN)  ? sync2_q[0] :
                    (clk_src == vip_pkg::VIP_CLK_XCLK) ? sync2_q[2] : sync2_q[1];
   assign trdy    = sync2_q[3];
   assign float_s = sync2_q[4];
   assign fall    = clk_prev_q && !sel_clk && (gap_q >= 4'(`VIP_PORT_MIN_GAP));

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         clk_prev_q <= 1'b0;
         gap_q      <= 4'h0;
      end else begin
         clk_prev_q <= sel_clk;
         if (fall) begin
            gap_q <= 4'h0;
         end else if (gap_q != 4'hf) begin
            gap_q <= gap_q + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scaler holding word and blanking line buffer

   vip_pkg::vip_dword_t dw_q;
   logic                have_q, consume, clr_vbi;
   logic [7:0]          mem_q [VBI_DEPTH];
   logic [CNT_W-1:0]    vbi_cnt_q, rd_q, rd_d, rd_nx;
   logic                vbi_full_q, vbi_wr;

   // one word held, scaler stalls behind it
   assign SC_READY_OUT  = !have_q;
   assign VBI_READY_OUT = !vbi_full_q;
   assign vbi_wr        = VBI_VALID_IN && !vbi_full_q;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         have_q <= 1'b0;
         dw_q   <= '0;
      end else if (SC_VALID_IN && !have_q) begin
         have_q <= 1'b1;
         dw_q   <= SC_DWORD_IN;
      end else if (consume && fall) begin
         have_q <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (vbi_wr) mem_q[vbi_cnt_q[$clog2(VBI_DEPTH)-1:0]] <= VBI_BYTE_IN.data;
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         vbi_cnt_q  <= '0;
         vbi_full_q <= 1'b0;
      end else if (vbi_wr) begin
         vbi_cnt_q  <= vbi_cnt_q + CNT_W'(1);
         vbi_full_q <= VBI_BYTE_IN.last || (vbi_cnt_q == CNT_W'(VBI_DEPTH - 1));
      end else if (clr_vbi && fall) begin
         vbi_cnt_q  <= '0;
         vbi_full_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // byte selection

   logic [2:0] step, idx_q, idx_d, idx_nx;
   logic [7:0] b_even, b_odd, b_ser, w_lo, w_hi, vid_lo, vid_hi;
   logic [7:0] vbi_lo, vbi_hi, vbi_raw_lo, vbi_raw_hi;
   logic       line_f_q, line_v_q, lane_y_low;

   // two bytes per cycle when wide
   assign step   = wide ? 3'd2 : 3'd1;
   assign idx_nx = idx_q + step;
   assign rd_nx  = rd_q + CNT_W'(step);

   // dword split into bytes or lane pairs
   assign b_even     = dw_byte(dw_q.data, {idx_q[1], 1'b0});
   assign b_odd      = dw_byte(dw_q.data, {idx_q[1], 1'b1});
   assign b_ser      = dw_byte(dw_q.data, {idx_q[1], idx_q[0] ^ mode_q[0] ^ pol_q[6]});
   assign lane_y_low = (fmt == vip_pkg::VIP_FMT_422) ^ pol_q[7];
   assign w_lo       = lane_y_low ? b_odd : b_even;
   assign w_hi       = lane_y_low ? b_even : b_odd;
   // video and raw bytes clipped off 00h and FFh; upper byte is 00h when narrow
   assign vid_lo     = clip(wide ? w_lo : b_ser);
   assign vid_hi     = wide ? clip(w_hi) : `VIP_BYTE_INVALID;

   assign vbi_raw_lo = mem_q[rd_q[$clog2(VBI_DEPTH)-1:0]];
   assign vbi_raw_hi = (rd_q + CNT_W'(1) < vbi_cnt_q) ? mem_q[rd_nx[$clog2(VBI_DEPTH)-1:0] - 1'b1] :
                       `VIP_BYTE_INVALID;
   assign vbi_lo     = recode_on ? recode(vbi_raw_lo) : vbi_raw_lo;
   assign vbi_hi     = !wide ? `VIP_BYTE_INVALID : recode_on ? recode(vbi_raw_hi) : vbi_raw_hi;

   ////////////////////////////////////////////////////////////////////////////
   // output sequencer

   vip_pkg::vip_state_t state_q, state_d;
   logic                ev, anc_flag, start_line;
   logic [7:0]          lo, hi;

   always_comb begin
      state_d    = state_q;
      idx_d      = idx_q;
      rd_d       = rd_q;
      consume    = 1'b0;
      clr_vbi    = 1'b0;
      ev         = 1'b0;
      anc_flag   = 1'b0;
      start_line = 1'b0;
      lo         = `VIP_BYTE_INVALID;
      hi         = `VIP_BYTE_INVALID;
      case (state_q)
         vip_pkg::VIP_ST_IDLE: begin
            idx_d = 3'd0;
            rd_d  = '0;
            if (vbi_full_q && trdy) begin
               if (vbi_cnt_q == '0) begin
                  clr_vbi = 1'b1;
               end else begin
                  state_d = codes ? vip_pkg::VIP_ST_ANC_HDR : vip_pkg::VIP_ST_ANC_DATA;
               end
            end else if (have_q) begin
               if (fmt == vip_pkg::VIP_FMT_VBI) begin
                  consume = 1'b1;
               end else begin
                  // codes only for lines with data
                  start_line = 1'b1;
                  state_d    = (codes && dw_q.first) ? vip_pkg::VIP_ST_SAV : vip_pkg::VIP_ST_DATA;
               end
            end
         end
         vip_pkg::VIP_ST_SAV, vip_pkg::VIP_ST_EAV: begin
            ev    = 1'b1;
            lo    = code_byte(idx_q, line_f_q, line_v_q, state_q == vip_pkg::VIP_ST_EAV);
            hi    = wide ? code_byte(idx_nx - 3'd1, line_f_q, line_v_q, state_q == vip_pkg::VIP_ST_EAV) :
                    `VIP_BYTE_INVALID;
            idx_d = idx_nx;
            if (idx_nx >= `VIP_CODE_LEN) begin
               idx_d   = 3'd0;
               state_d = (state_q == vip_pkg::VIP_ST_SAV) ? vip_pkg::VIP_ST_DATA : vip_pkg::VIP_ST_IDLE;
            end
         end
         vip_pkg::VIP_ST_DATA: begin
            // hold off while target not ready
            if (have_q && trdy) begin
               ev    = 1'b1;
               lo    = vid_lo;
               hi    = vid_hi;
               idx_d = idx_nx;
               if (idx_nx >= `VIP_CODE_LEN) begin
                  consume = 1'b1;
                  idx_d   = 3'd0;
                  if (dw_q.last) state_d = codes ? vip_pkg::VIP_ST_EAV : vip_pkg::VIP_ST_IDLE;
               end
            end
         end
         // header and data back to back
         vip_pkg::VIP_ST_ANC_HDR: begin
            ev       = 1'b1;
            anc_flag = 1'b1;
            lo       = anc_byte(idx_q, 8'(vbi_cnt_q));
            hi       = wide ? anc_byte(idx_nx - 3'd1, 8'(vbi_cnt_q)) : `VIP_BYTE_INVALID;
            idx_d    = idx_nx;
            if (idx_nx >= `VIP_ANC_HDR_LEN) begin
               idx_d   = 3'd0;
               state_d = vip_pkg::VIP_ST_ANC_DATA;
            end
         end
         vip_pkg::VIP_ST_ANC_DATA: begin
            ev       = 1'b1;
            anc_flag = 1'b1;
            lo       = vbi_lo;
            hi       = vbi_hi;
            rd_d     = rd_nx;
            if (rd_nx >= vbi_cnt_q) begin
               clr_vbi = 1'b1;
               state_d = vip_pkg::VIP_ST_IDLE;
            end
         end
         default: begin
            state_d = vip_pkg::VIP_ST_IDLE;
         end
      endcase
   end

   logic       valid_q, anc_q, clk_out_q;
   logic [7:0] lo_q, hi_q;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         state_q  <= vip_pkg::VIP_ST_IDLE;
         idx_q    <= 3'd0;
         rd_q     <= '0;
         line_f_q <= 1'b0;
         line_v_q <= 1'b0;
         valid_q  <= 1'b0;
         anc_q    <= 1'b0;
         lo_q     <= `VIP_BYTE_INVALID;
         hi_q     <= `VIP_BYTE_INVALID;
      end else if (fall) begin
         state_q <= state_d;
         idx_q   <= idx_d;
         rd_q    <= rd_d;
         valid_q <= ev;
         anc_q   <= anc_flag;
         lo_q    <= lo;
         hi_q    <= hi;
         if (start_line) begin
            line_f_q <= dw_q.field;
            line_v_q <= dw_q.vblank || (fmt == vip_pkg::VIP_FMT_RAW);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins

   logic hgate_q, hprev_q, vgate_q, vprev_q;
   logic href_q, vref_q, flag_a_q, flag_b_q;
   logic data_oe_q, ext_oe_q, clk_oe_q, ctrl_oe_q;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         hgate_q   <= 1'b0;
         hprev_q   <= 1'b0;
         vgate_q   <= 1'b0;
         vprev_q   <= 1'b0;
         href_q    <= 1'b0;
         vref_q    <= 1'b0;
         flag_a_q  <= 1'b0;
         flag_b_q  <= 1'b0;
         clk_out_q <= 1'b0;
         data_oe_q <= 1'b0;
         ext_oe_q  <= 1'b0;
         clk_oe_q  <= 1'b0;
         ctrl_oe_q <= 1'b0;
      end else begin
         hgate_q   <= SC_HGATE_IN;
         hprev_q   <= hgate_q;
         vgate_q   <= SC_VGATE_IN;
         vprev_q   <= vgate_q;
         clk_out_q <= sel_clk;
         href_q    <= ref_fn(ref_sel_q[1:0], hgate_q, hgate_q && !hprev_q, state_q != vip_pkg::VIP_ST_IDLE)
                      ^ pol_q[`VIP_BIT_HPOL];
         vref_q    <= ref_fn(ref_sel_q[3:2], vgate_q, vgate_q && !vprev_q, line_f_q) ^ pol_q[`VIP_BIT_VPOL];
         flag_b_q  <= ref_fn(ref_sel_q[5:4], anc_q, vbi_full_q, have_q) ^ pol_q[`VIP_BIT_BPOL];
         flag_a_q  <= ref_fn(ref_sel_q[7:6], anc_q, vbi_full_q, have_q) ^ pol_q[`VIP_BIT_APOL];
         data_oe_q <= port_en_q[0] && !float_s;
         ext_oe_q  <= port_en_q[0] && !float_s && wide;
         clk_oe_q  <= port_en_q[0] && !float_s && (clk_src != vip_pkg::VIP_CLK_PIN);
         ctrl_oe_q <= port_en_q[1] && !float_s;
      end
   end

   assign status = {4'h0, vbi_full_q, have_q, valid_q, state_q != vip_pkg::VIP_ST_IDLE};

   assign PORT_CLOCK_PIN_OUT          = clk_out_q;
   assign PORT_CLOCK_PIN_OE_OUT       = clk_oe_q;
   assign LOW_DATA_PINS_OUT           = lo_q;
   assign LOW_DATA_PINS_OE_OUT        = data_oe_q;
   assign EXTENSION_DATA_PINS_OUT     = hi_q;
   assign EXTENSION_DATA_PINS_OE_OUT  = ext_oe_q;
   assign DATA_VALID_QUALIFIER_OUT    = gated ? (clk_out_q && valid_q) : (valid_q ^ pol_q[`VIP_BIT_QPOL]);
   assign HORIZ_REFERENCE_OUT         = href_q;
   assign VERT_REFERENCE_OUT          = vref_q;
   assign GENERAL_FLAG_OUT_A          = flag_a_q;
   assign GENERAL_FLAG_OUT_B          = flag_b_q;
   assign CTRL_PINS_OE_OUT            = ctrl_oe_q;

endmodule

//--- hdl/vip_pkg.sv
package vip_pkg;

   typedef struct packed {
      logic [31:0] data;
      logic        first;
      logic        last;
      logic        vblank;
      logic        field;
   } vip_dword_t;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } vip_vbi_byte_t;

   typedef enum logic [1:0] {
      VIP_CLK_PIN  = 2'h0,
      VIP_CLK_LLC  = 2'h1,
      VIP_CLK_XCLK = 2'h2,
      VIP_CLK_ALT  = 2'h3
   } vip_clk_src_t;

   typedef enum logic [1:0] {
      VIP_FMT_422 = 2'h0,
      VIP_FMT_411 = 2'h1,
      VIP_FMT_RAW = 2'h2,
      VIP_FMT_VBI = 2'h3
   } vip_format_t;

   typedef enum logic [2:0] {
      VIP_ST_IDLE     = 3'b000,
      VIP_ST_SAV      = 3'b001,
      VIP_ST_DATA     = 3'b011,
      VIP_ST_EAV      = 3'b010,
      VIP_ST_ANC_HDR  = 3'b110,
      VIP_ST_ANC_DATA = 3'b111
   } vip_state_t;

endpackage

//--- verif/tb_vip_image_port.sv
`timescale 1ns/100ps
`include "vip_defines.svh"
module tb_vip_image_port;
   logic REF_CLK_IN, RESETN_IN, REG_WR_IN, REG_RD_IN, PORT_CLOCK_PIN_IN, TARGET_READY_IN, PORT_FLOAT_IN;
   logic SC_VALID_IN, SC_READY_OUT, SC_HGATE_IN, SC_VGATE_IN, VBI_VALID_IN, VBI_READY_OUT, CTRL_PINS_OE_OUT;
   logic PORT_CLOCK_PIN_OUT, PORT_CLOCK_PIN_OE_OUT, LOW_DATA_PINS_OE_OUT, EXTENSION_DATA_PINS_OE_OUT;
   logic DATA_VALID_QUALIFIER_OUT, HORIZ_REFERENCE_OUT, VERT_REFERENCE_OUT, GENERAL_FLAG_OUT_A, GENERAL_FLAG_OUT_B;
   logic [7:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT, LOW_DATA_PINS_OUT, EXTENSION_DATA_PINS_OUT, exp_q[$];
   logic LLC_CLK_IN = 1'b0, XCLK_IN = 1'b0, stall, qpol, flag_seen = 1'b0, q_prev = 1'b0;
   int n_errors = 0, compares = 0, n_qrise = 0, g0 = 0;
   vip_pkg::vip_dword_t SC_DWORD_IN;
   vip_pkg::vip_vbi_byte_t VBI_BYTE_IN;
   vip_image_port #(.VBI_DEPTH(8)) vip_image_port_inst (.*);
   vip_rx_model vip_rx_model_inst (.stall_in(stall), .qpol_in(qpol), .data_in(LOW_DATA_PINS_OUT),
      .qual_in(DATA_VALID_QUALIFIER_OUT), .clk_out(PORT_CLOCK_PIN_IN), .ready_out(TARGET_READY_IN));
   initial begin
      REF_CLK_IN = 1'b0;
      forever #20 REF_CLK_IN = !REF_CLK_IN;
   end
   // flag and qualifier pulse watch
   always @(posedge REF_CLK_IN) begin
      if (GENERAL_FLAG_OUT_A === 1'b1) flag_seen <= 1'b1;
      if (DATA_VALID_QUALIFIER_OUT === 1'b1 && q_prev !== 1'b1) n_qrise <= n_qrise + 1;
      q_prev <= DATA_VALID_QUALIFIER_OUT;
   end
   initial begin
      #200000;
      n_errors++;
      $display("mismatch at %0t: timeout", $time);
      end_sim;
   end
   ////////////////////////////////
   task cyc(input int n);
      repeat (n) @(posedge REF_CLK_IN);
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      {REG_ADDR_IN, REG_WDATA_IN, REG_WR_IN} <= {a, d, 1'b1};
      cyc(1);
      REG_WR_IN <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      cyc(1);
      {REG_ADDR_IN, REG_RD_IN} <= {a, 1'b1};
      cyc(1);
      REG_RD_IN <= 1'b0;
      cyc(1);
      chk(REG_RDATA_OUT, exp);
   endtask
   task put_dw(input logic [31:0] d);
      cyc(1);
      {SC_DWORD_IN, SC_VALID_IN} <= {d, 4'hc, 1'b1};
      do cyc(1); while (SC_READY_OUT !== 1'b1);
      SC_VALID_IN <= 1'b0;
   endtask
   task put_vb(input logic [8:0] b);
      cyc(1);
      {VBI_BYTE_IN, VBI_VALID_IN} <= {b, 1'b1};
      do cyc(1); while (VBI_READY_OUT !== 1'b1);
      VBI_VALID_IN <= 1'b0;
   endtask
   task cmp_rx;
      logic [7:0] m;
      chk(8'(vip_rx_model_inst.got.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) begin
         m = ((exp_q[i] & 8'hef) == 8'h80) ? 8'hf0 : 8'hff;
         if (i < vip_rx_model_inst.got.size()) chk(vip_rx_model_inst.got[i] & m, exp_q[i]);
      end
      vip_rx_model_inst.got.delete();
   endtask
   task end_sim;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      {RESETN_IN, REG_WR_IN, REG_RD_IN, PORT_FLOAT_IN, SC_VALID_IN, SC_HGATE_IN, SC_VGATE_IN, VBI_VALID_IN} = '0;
      {REG_ADDR_IN, REG_WDATA_IN, SC_DWORD_IN, VBI_BYTE_IN, stall, qpol} = '0;
      cyc(8);
      RESETN_IN <= 1'b1;
      rd(8'h87, 8'h03);
      rd(8'h20, 8'h00);
      wr(8'h84, 8'h01);
      rd(8'h84, 8'h01);
      wr(8'h93, 8'h80);
      rd(8'h93, 8'h80);
      {stall, SC_HGATE_IN, SC_VGATE_IN} <= 3'h7;
      put_dw(32'h00ff_5510);
      cyc(120);
      chk(8'(vip_rx_model_inst.got.size() == 4), 8'h01);
      chk(8'(VERT_REFERENCE_OUT), 8'h01);
      {stall, SC_HGATE_IN, SC_VGATE_IN} <= 3'h0;
      cyc(250);
      exp_q = '{8'hff, 8'h00, 8'h00, 8'h80, 8'h10, 8'h55, 8'hfe, 8'h01, 8'hff, 8'h00, 8'h00, 8'h90};
      cmp_rx();
      wr(8'h8e, 8'h04);
      put_vb({8'h00, 1'b0});
      put_vb({8'hff, 1'b1});
      cyc(300);
      exp_q = '{8'h00, 8'hff, 8'hff, `VIP_ANC_DID, `VIP_ANC_SDID, 8'h02, 8'h03, 8'hfc};
      cmp_rx();
      chk(8'(flag_seen), 8'h01);
      wr(8'h85, 8'h01);
      qpol <= 1'b1;
      cyc(4);
      chk(8'(DATA_VALID_QUALIFIER_OUT), 8'h01);
      chk(LOW_DATA_PINS_OUT, 8'h00);
      wr(8'h85, 8'h00);
      qpol <= 1'b0;
      wr(8'h80, 8'h04);
      g0 = n_qrise;
      put_dw(32'h1234_5678);
      cyc(150);
      chk(8'(n_qrise - g0), 8'h0c);
      wr(8'h80, 8'h00);
      wr(8'h93, 8'hc0);
      put_dw(32'h00ff_5510);
      cyc(120);
      exp_q = '{8'hff, 8'h00, 8'h55, 8'h01, 8'hff, 8'h00};
      cmp_rx();
      wr(8'h93, 8'h40);
      cyc(4);
      chk(8'(EXTENSION_DATA_PINS_OE_OUT), 8'h01);
      wr(8'h93, 8'h00);
      cyc(4);
      chk(8'(EXTENSION_DATA_PINS_OE_OUT), 8'h00);
      wr(8'h80, 8'h01);
      cyc(4);
      chk(8'(PORT_CLOCK_PIN_OE_OUT), 8'h01);
      chk(8'(CTRL_PINS_OE_OUT), 8'h01);
      PORT_FLOAT_IN <= 1'b1;
      cyc(6);
      chk(8'(LOW_DATA_PINS_OE_OUT), 8'h00);
      chk(8'(PORT_CLOCK_PIN_OE_OUT), 8'h00);
      chk(8'(CTRL_PINS_OE_OUT), 8'h00);
      chk(EXTENSION_DATA_PINS_OUT, 8'h00);
      end_sim;
   end
endmodule

//--- verif/vip_ipm_chk_monitor.sv
`timescale 1ns/100ps
module vip_ipm_chk (
   input wire logic       REF_CLK_IN,
   input wire logic       RESETN_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic       REG_WR_IN,
   input wire logic       REG_RD_IN,
   input wire logic [7:0] REG_RDATA_OUT,
   input wire logic       PORT_FLOAT_IN,
   input wire logic       PORT_CLOCK_PIN_OUT,
   input wire logic [7:0] LOW_DATA_PINS_OUT,
   input wire logic       LOW_DATA_PINS_OE_OUT,
   input wire logic       EXTENSION_DATA_PINS_OE_OUT,
   input wire logic       DATA_VALID_QUALIFIER_OUT,
   input wire logic       HORIZ_REFERENCE_OUT
);
   logic [7:0] ctl_q, sel_q, pol_q, mod_q;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   // mirror of written settings
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) {ctl_q, sel_q, pol_q, mod_q} <= '0;
      else if (REG_WR_IN && REG_ADDR_IN == 8'h80) ctl_q <= REG_WDATA_IN;
      else if (REG_WR_IN && REG_ADDR_IN == 8'h84) sel_q <= REG_WDATA_IN;
      else if (REG_WR_IN && REG_ADDR_IN == 8'h85) pol_q <= REG_WDATA_IN;
      else if (REG_WR_IN && REG_ADDR_IN == 8'h93) mod_q <= REG_WDATA_IN;
   end
   property p_idle_zero; !ctl_q[2] && $stable(pol_q) && !(DATA_VALID_QUALIFIER_OUT ^ pol_q[0])
      |-> LOW_DATA_PINS_OUT == 8'h00; endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("idle data not zero");
   property p_ext_oe; EXTENSION_DATA_PINS_OE_OUT |-> mod_q[6] || $past(mod_q[6]); endproperty
   a_ext_oe: assert property (p_ext_oe) else $error("extension driven in narrow mode");
   property p_float; PORT_FLOAT_IN [*4] |-> !LOW_DATA_PINS_OE_OUT && !EXTENSION_DATA_PINS_OE_OUT; endproperty
   a_float: assert property (p_float) else $error("port not floated");
   property p_gated; ctl_q[2] && $past(ctl_q[2]) && DATA_VALID_QUALIFIER_OUT |-> PORT_CLOCK_PIN_OUT; endproperty
   a_gated: assert property (p_gated) else $error("gated qualifier without clock");
   property p_hpulse; sel_q[1:0] == 2'h1 && $stable(sel_q) && !pol_q[1] && HORIZ_REFERENCE_OUT
      |=> !HORIZ_REFERENCE_OUT; endproperty
   a_hpulse: assert property (p_hpulse) else $error("reference pulse too long");
   property p_rd_pol; REG_RD_IN && REG_ADDR_IN == 8'h85 |=> REG_RDATA_OUT == pol_q; endproperty
   a_rd_pol: assert property (p_rd_pol) else $error("polarity readback wrong");
   property p_rd_sel; REG_RD_IN && REG_ADDR_IN == 8'h84 |=> REG_RDATA_OUT == sel_q; endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("pin function readback wrong");
   property p_rd_mod; REG_RD_IN && REG_ADDR_IN == 8'h93 |=> REG_RDATA_OUT == (mod_q & 8'hc0); endproperty
   a_rd_mod: assert property (p_rd_mod) else $error("mode readback wrong");
endmodule
bind vip_image_port vip_ipm_chk vip_ipm_chk_inst (.*);

//--- verif/vip_rx_model.sv
`timescale 1ns/100ps
module vip_rx_model (
   input  wire logic       stall_in,
   input  wire logic       qpol_in,
   input  wire logic [7:0] data_in,
   input  wire logic       qual_in,
   output logic            clk_out,
   output logic            ready_out
);
   logic [7:0] got[$];
   assign ready_out = !stall_in;
   initial begin
      clk_out = 1'b0;
      forever #160 clk_out = !clk_out;
   end
   always @(posedge clk_out) if (qual_in ^ qpol_in) got.push_back(data_in);
endmodule
